// *** verilog/pllreg_pkg.sv ***
// Purpose: Constants for the synthesiser divider and VCO register group.
// Assumes: Avalon-MM word addressing; each register is one aligned word.
// Notes:   Each index names one 32-bit word; only its low byte is used.
//
// How it works
// - Feedback divisor spans three bytes; applied when top byte written.
// - Loop-enable bit 7 and charge-pump bit 5 act immediately on write.
// - Loop runs only with loop-enable and general control bit 2 set.
// - Loop-enable written zero disables loop, allowing an external LO.
// - Charge-pump bit one enables pump, zero puts it high impedance.
// - Host writes zero to bit 6; reading that bit returns lock status.
// - Every divider write register has a read address returning its value.
// - Top feedback readback shows lock-detect state in bit 6.
// - Reference divisor spans two bytes; takes effect when upper written.
// - General reset command clears the VCO tuning register to zero.
// - Two low VCO bits select oscillator negative resistance, 0 maximum.
// - VCO runs only when general control bit 3 is one.
// - VCO tuning readback address returns current tuning register.

`default_nettype none

package pllreg_pkg;
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] IDX_FB_LOW      = 8'h2A;
  localparam logic [7:0] IDX_FB_MID      = 8'h2B;
  localparam logic [7:0] IDX_FB_TOP      = 8'h2C;
  localparam logic [7:0] IDX_REF_LOW     = 8'h2D;
  localparam logic [7:0] IDX_REF_HIGH    = 8'h2E;
  localparam logic [7:0] IDX_VCO_TUNE    = 8'h2F;
  localparam logic [7:0] IDX_FB_LOW_RB   = 8'hDA;
  localparam logic [7:0] IDX_FB_MID_RB   = 8'hDB;
  localparam logic [7:0] IDX_FB_TOP_RB   = 8'hDC;
  localparam logic [7:0] IDX_REF_LOW_RB  = 8'hDD;
  localparam logic [7:0] IDX_REF_HIGH_RB = 8'hDE;
  localparam logic [7:0] IDX_VCO_TUNE_RB = 8'hDF;
  localparam logic [7:0] IDX_GEN_CTRL    = 8'h40;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h41;
  localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h42;
  localparam logic [7:0] IDX_IRQ_CLEAR   = 8'h43;
  localparam logic [7:0] IDX_GEN_RESET   = 8'h44;
  localparam int BIT_LOOP_EN  = 7;
  localparam int BIT_LOCK     = 6;
  localparam int BIT_PUMP_ON  = 5;
  localparam int BIT_GC_PLL   = 2;
  localparam int BIT_GC_VCO   = 3;
  localparam int IRQ_FB_COMMIT  = 0;
  localparam int IRQ_REF_COMMIT = 1;
  localparam int IRQ_LOCK_GAIN  = 2;
  localparam int IRQ_LOCK_LOSS  = 3;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [17:0] RST_FB_DIV  = 18'h00000;
  localparam logic [15:0] RST_REF_DIV = 16'h0000;
  localparam logic [3:0]  RST_IRQ     = 4'h0;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
endpackage : pllreg_pkg

`default_nettype wire

// *** verilog/pllreg_top.sv ***
// Purpose: Register group for synthesiser dividers, loop control and VCO.
// Assumes: Avalon-MM slave, one wait state on every access.
// Notes:   Lock flag comes from the analogue loop and is sampled as is.
//
// The Avalon-MM slave port was left to the implementer.

`timescale 1ns/1ps
`default_nettype none

module pllreg_top
  import pllreg_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // Avalon-MM slave.
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Synthesiser status and controls.
  input  wire logic        lock_flag_in,
  output logic      [17:0] feedback_divisor_out,
  output logic      [15:0] reference_divisor_out,
  output logic             loop_run_out,
  output logic             charge_pump_on_out,
  output logic             vco_enable_out,
  output logic      [5:0]  mixer_linearity_trim_out,
  output logic             osc_neg_resistance_hi_out,
  output logic             osc_neg_resistance_lo_out,
  // Interrupt.
  output logic             irq_out
);

  logic [7:0]  fb_low_q, fb_mid_q, fb_top_q, ref_low_q, ref_high_q;
  logic [7:0]  vco_q, gen_ctrl_q;
  logic [3:0]  irq_sts_q, irq_en_q;
  logic        ack_q, lock_q;
  logic [31:0] rdata_q;

  wire req     = (avs_read_in | avs_write_in) & ~ack_q;
  wire wr_go   = avs_write_in & ack_q & avs_byteenable_in[0];
  wire rd_go   = avs_read_in & ~ack_q;
  wire [7:0] wb = avs_writedata_in[7:0];
  wire wr_fbl  = wr_go & (avs_address_in == IDX_FB_LOW);
  wire wr_fbm  = wr_go & (avs_address_in == IDX_FB_MID);
  wire wr_fbt  = wr_go & (avs_address_in == IDX_FB_TOP);
  wire wr_rfl  = wr_go & (avs_address_in == IDX_REF_LOW);
  wire wr_rfh  = wr_go & (avs_address_in == IDX_REF_HIGH);
  wire wr_vco  = wr_go & (avs_address_in == IDX_VCO_TUNE);
  wire wr_gc   = wr_go & (avs_address_in == IDX_GEN_CTRL);
  wire wr_ien  = wr_go & (avs_address_in == IDX_IRQ_ENABLE);
  wire wr_iclr = wr_go & (avs_address_in == IDX_IRQ_CLEAR);
  wire wr_grst = wr_go & (avs_address_in == IDX_GEN_RESET) & wb[0];

  // Bit 6 of the top byte is never stored: its readback is the lock flag.
  wire [7:0] fb_top_rb = {fb_top_q[7], lock_flag_in,
                          fb_top_q[5:0]};

  logic [7:0] rd_byte;
  always_comb begin
    unique case (avs_address_in)
      IDX_FB_LOW_RB:   rd_byte = fb_low_q;
      IDX_FB_MID_RB:   rd_byte = fb_mid_q;
      IDX_FB_TOP_RB:   rd_byte = fb_top_rb;
      IDX_REF_LOW_RB:  rd_byte = ref_low_q;
      IDX_REF_HIGH_RB: rd_byte = ref_high_q;
      IDX_VCO_TUNE_RB: rd_byte = vco_q;
      IDX_GEN_CTRL:    rd_byte = gen_ctrl_q;
      IDX_IRQ_STATUS:  rd_byte = {4'h0, irq_sts_q};
      IDX_IRQ_ENABLE:  rd_byte = {4'h0, irq_en_q};
      default:         rd_byte = RD_UNMAPPED[7:0];
    endcase
  end

  wire lock_rise = lock_flag_in & ~lock_q;
  wire lock_fall = ~lock_flag_in & lock_q;
  wire [3:0] irq_set;
  assign irq_set[IRQ_FB_COMMIT]  = wr_fbt;
  assign irq_set[IRQ_REF_COMMIT] = wr_rfh;
  assign irq_set[IRQ_LOCK_GAIN]  = lock_rise;
  assign irq_set[IRQ_LOCK_LOSS]  = lock_fall;
  // Set wins over a clear in the same cycle so no event is lost.
  wire [3:0] irq_sts_d = (irq_sts_q & ~(wr_iclr ? wb[3:0] : 4'h0)) | irq_set;

  // Bus handshake: every access waits exactly one cycle, and a write lands
  // on the edge that ends the cycle with waitrequest low; a held request acts again every second cycle.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_q               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      rdata_q             <= RD_UNMAPPED;
    end else begin
      ack_q               <= req;
      avs_waitrequest_out <= ~req;
      rdata_q             <= rd_go ? {24'h000000, rd_byte} : rdata_q;
    end
  end

  // Staging bytes only; the active divisors change on the top byte.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fb_low_q  <= RST_BYTE;
      fb_mid_q  <= RST_BYTE;
      ref_low_q <= RST_BYTE;
    end else begin
      fb_low_q  <= wr_fbl ? wb : fb_low_q;
      fb_mid_q  <= wr_fbm ? wb : fb_mid_q;
      ref_low_q <= wr_rfl ? wb : ref_low_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fb_top_q              <= RST_BYTE;
      ref_high_q            <= RST_BYTE;
      feedback_divisor_out  <= RST_FB_DIV;
      reference_divisor_out <= RST_REF_DIV;
    end else begin
      if (wr_fbt) begin
        fb_top_q             <= {wb[7], 1'b0, wb[5:0]};
        feedback_divisor_out <= {wb[1:0], fb_mid_q, fb_low_q};
      end
      if (wr_rfh) begin
        ref_high_q            <= wb;
        reference_divisor_out <= {wb, ref_low_q};
      end
    end
  end

  // A fresh write wins over the stored byte, so the pump and loop switch
  // on the same edge that stores the byte instead of one cycle later.
  wire pump_d   = wr_fbt ? wb[BIT_PUMP_ON] : fb_top_q[BIT_PUMP_ON];
  wire loop_d   = wr_fbt ? wb[BIT_LOOP_EN] : fb_top_q[BIT_LOOP_EN];
  wire gc_pll_d = wr_gc ? wb[BIT_GC_PLL] : gen_ctrl_q[BIT_GC_PLL];
  wire gc_vco_d = wr_gc ? wb[BIT_GC_VCO] : gen_ctrl_q[BIT_GC_VCO];

  // Loop and pump controls follow the top byte write at once.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      charge_pump_on_out <= 1'b0;
      loop_run_out       <= 1'b0;
      vco_enable_out     <= 1'b0;
    end else begin
      charge_pump_on_out <= pump_d;
      loop_run_out       <= loop_d & gc_pll_d;
      vco_enable_out     <= gc_vco_d;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      vco_q      <= RST_BYTE;
      gen_ctrl_q <= RST_BYTE;
    end else begin
      vco_q      <= wr_grst ? RST_BYTE : (wr_vco ? wb : vco_q);
      gen_ctrl_q <= wr_gc ? wb : gen_ctrl_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_sts_q <= RST_IRQ;
      irq_en_q  <= RST_IRQ;
      irq_out   <= 1'b0;
      lock_q    <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_en_q  <= wr_ien ? wb[3:0] : irq_en_q;
      irq_out   <= |(irq_sts_d & (wr_ien ? wb[3:0] : irq_en_q));
      lock_q    <= lock_flag_in;
    end
  end

  // Trim resets to zero; software should load all ones for best linearity.
  assign mixer_linearity_trim_out  = vco_q[7:2];
  assign osc_neg_resistance_hi_out = vco_q[1];
  assign osc_neg_resistance_lo_out = vco_q[0];
  assign avs_readdata_out          = rdata_q;

  property p_fb_commit;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbt |=> feedback_divisor_out == {$past(wb[1:0]), fb_mid_q, fb_low_q};
  endproperty
  a_fb_commit: assert property (p_fb_commit)
    else $error("feedback divisor not committed");

  property p_fb_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (wr_fbl | wr_fbm) && !wr_fbt |=> $stable(feedback_divisor_out);
  endproperty
  a_fb_hold: assert property (p_fb_hold)
    else $error("feedback divisor changed before top byte");

  property p_ref_commit;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_rfh |=> reference_divisor_out == {$past(wb), ref_low_q};
  endproperty
  a_ref_commit: assert property (p_ref_commit)
    else $error("reference divisor not committed");

  property p_pump;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbt |=> charge_pump_on_out == $past(wb[BIT_PUMP_ON]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("charge pump bit not applied");

  property p_loop;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ##1 loop_run_out == (fb_top_q[BIT_LOOP_EN] & gen_ctrl_q[BIT_GC_PLL]);
  endproperty
  a_loop: assert property (p_loop)
    else $error("loop run mismatch");

  property p_grst;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_grst |=> vco_q == 8'h00 && mixer_linearity_trim_out == 6'h00;
  endproperty
  a_grst: assert property (p_grst)
    else $error("vco register not cleared");

  property p_lock_rb;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    avs_read_in && !ack_q && avs_address_in == IDX_FB_TOP_RB
      |=> avs_readdata_out[BIT_LOCK] == $past(lock_flag_in)
          && !avs_waitrequest_out;
  endproperty
  a_lock_rb: assert property (p_lock_rb)
    else $error("lock flag not in readback");

  property p_vco_rb;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    avs_read_in && !ack_q && avs_address_in == IDX_VCO_TUNE_RB
      |=> avs_readdata_out == {24'h000000, $past(vco_q)};
  endproperty
  a_vco_rb: assert property (p_vco_rb)
    else $error("vco readback wrong");

  property p_loop_now;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbt |=> loop_run_out
               == ($past(wb[BIT_LOOP_EN]) & gen_ctrl_q[BIT_GC_PLL]);
  endproperty
  a_loop_now: assert property (p_loop_now)
    else $error("loop enable not applied at once");

  property p_loop_off;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbt && !wb[BIT_LOOP_EN] |=> !loop_run_out;
  endproperty
  a_loop_off: assert property (p_loop_off)
    else $error("loop still runs after disable");

  property p_gc_off;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_gc && !wb[BIT_GC_PLL] |=> !loop_run_out;
  endproperty
  a_gc_off: assert property (p_gc_off)
    else $error("loop runs without general enable");

  property p_pump_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !wr_fbt |=> $stable(charge_pump_on_out);
  endproperty
  a_pump_hold: assert property (p_pump_hold)
    else $error("charge pump changed without write");

  property p_vco_en;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_gc |=> vco_enable_out == $past(wb[BIT_GC_VCO]);
  endproperty
  a_vco_en: assert property (p_vco_en)
    else $error("vco enable not applied");

  property p_vco_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !wr_gc |=> $stable(vco_enable_out);
  endproperty
  a_vco_hold: assert property (p_vco_hold)
    else $error("vco enable changed without write");

  property p_no_lock_store;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    !fb_top_q[BIT_LOCK];
  endproperty
  a_no_lock_store: assert property (p_no_lock_store)
    else $error("lock bit position was stored");

  property p_low_stage;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbl |=> fb_low_q == $past(wb);
  endproperty
  a_low_stage: assert property (p_low_stage)
    else $error("feedback low byte not staged");

  property p_mid_stage;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fbm |=> fb_mid_q == $past(wb);
  endproperty
  a_mid_stage: assert property (p_mid_stage)
    else $error("feedback middle byte not staged");

  property p_rlow_stage;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_rfl |=> ref_low_q == $past(wb);
  endproperty
  a_rlow_stage: assert property (p_rlow_stage)
    else $error("reference low byte not staged");

  property p_ref_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_rfl |=> $stable(reference_divisor_out);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference divisor changed before upper byte");

  property p_mid_rb;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    avs_read_in && !ack_q && avs_address_in == IDX_FB_MID_RB
      |=> avs_readdata_out == {24'h000000, $past(fb_mid_q)};
  endproperty
  a_mid_rb: assert property (p_mid_rb)
    else $error("feedback middle readback wrong");

  property p_rhigh_rb;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    avs_read_in && !ack_q && avs_address_in == IDX_REF_HIGH_RB
      |=> avs_readdata_out == {24'h000000, $past(ref_high_q)};
  endproperty
  a_rhigh_rb: assert property (p_rhigh_rb)
    else $error("reference upper readback wrong");

  property p_neg_res;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vco |=> {osc_neg_resistance_hi_out, osc_neg_resistance_lo_out}
               == $past(wb[1:0]);
  endproperty
  a_neg_res: assert property (p_neg_res)
    else $error("negative resistance select not applied");

  property p_trim;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_vco |=> mixer_linearity_trim_out == $past(wb[7:2]);
  endproperty
  a_trim: assert property (p_trim)
    else $error("mixer trim not applied");

endmodule : pllreg_top

`default_nettype wire

// *** verif/pllreg_lock_model.sv ***
// Purpose: Behavioural stand-in for the analogue loop's lock detector.
// Assumes: Lock is reported seven cycles after the loop starts running.
// Notes:   Lock drops one cycle after the loop stops, so readback can see both.

`timescale 1ns/1ps
`default_nettype none

module pllreg_lock_model (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Loop state and lock report.
  input  wire logic run_in,
  output logic      lock_out
);
  logic [2:0] cnt_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 3'h0;
    end else if (!run_in) begin
      cnt_q <= 3'h0;
    end else if (cnt_q != 3'h7) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign lock_out = (cnt_q == 3'h7);
endmodule : pllreg_lock_model

`default_nettype wire

// *** verif/tb_pll_divider_vco_regs.sv ***
// Purpose: Self-checking bench for the synthesiser register group.
// Assumes: One wait state per access; byte lane 0 gates every write.
// Notes:   A stalled bus access is cut short by the cycle ceiling.

`timescale 1ns/1ps
`default_nettype none

module tb_pll_divider_vco_regs;
  import pllreg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic        rd      = 1'b0;
  logic        wr      = 1'b0;
  logic [7:0]  addr    = 8'h00;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  be      = 4'hF;
  logic [31:0] rdata, q;
  logic [17:0] fb;
  logic [15:0] rf;
  logic [5:0]  trim;
  logic        waitreq, lock, run, pump, vco, hi, lo, irq;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #2.5 sys_clk = ~sys_clk;

  pllreg_top u_dut (.sys_clk_in(sys_clk), .nrst_in(nrst),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .lock_flag_in(lock), .feedback_divisor_out(fb),
    .reference_divisor_out(rf), .loop_run_out(run),
    .charge_pump_on_out(pump), .vco_enable_out(vco),
    .mixer_linearity_trim_out(trim), .osc_neg_resistance_hi_out(hi),
    .osc_neg_resistance_lo_out(lo), .irq_out(irq));

  pllreg_lock_model u_lock (.clk_in(sys_clk), .nrst_in(nrst),
    .run_in(run), .lock_out(lock));

  task end_of_test();
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Holds the request until waitrequest is seen low, then idles one cycle.
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= {24'h000000, d};
    wr    <= w;
    rd    <= !w;
    do @(posedge sys_clk); while (waitreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task t_fb();
    bus(1'b1, IDX_GEN_CTRL, 8'h00);
    bus(1'b1, IDX_FB_LOW, 8'h34);
    bus(1'b1, IDX_FB_MID, 8'h12);
    chk("fb_staged", {14'h0, fb}, 32'h0);
    bus(1'b1, IDX_FB_TOP, 8'hA3);
    chk("fb_div", {14'h0, fb}, 32'h31234);
    chk("pump_on", {31'h0, pump}, 32'h1);
    chk("run_no_gc", {31'h0, run}, 32'h0);
    bus(1'b1, IDX_GEN_CTRL, 8'h0C);
    chk("run", {31'h0, run}, 32'h1);
    chk("vco_en", {31'h0, vco}, 32'h1);
    repeat (16) @(posedge sys_clk);
    bus(1'b0, IDX_FB_TOP_RB, 8'h00);
    chk("fb_top_rb", q, 32'hE3);
    bus(1'b0, IDX_FB_MID_RB, 8'h00);
    chk("fb_mid_rb", q, 32'h12);
    bus(1'b1, IDX_FB_LOW_RB, 8'hFF);
    bus(1'b0, IDX_FB_LOW_RB, 8'h00);
    chk("fb_low_rb", q, 32'h34);
    bus(1'b1, IDX_FB_TOP, 8'h00);
    chk("fb_div_off", {14'h0, fb}, 32'h01234);
    chk("run_off", {31'h0, run}, 32'h0);
    chk("pump_off", {31'h0, pump}, 32'h0);
    bus(1'b0, IDX_FB_TOP_RB, 8'h00);
    chk("fb_top_rb_unlk", q, 32'h00);
  endtask : t_fb

  task t_ref();
    bus(1'b1, IDX_REF_LOW, 8'h78);
    chk("ref_staged", {16'h0, rf}, 32'h0);
    bus(1'b1, IDX_REF_HIGH, 8'h56);
    chk("ref_div", {16'h0, rf}, 32'h5678);
    bus(1'b0, IDX_REF_LOW_RB, 8'h00);
    chk("ref_low_rb", q, 32'h78);
    bus(1'b0, IDX_REF_HIGH_RB, 8'h00);
    chk("ref_high_rb", q, 32'h56);
  endtask : t_ref

  task t_vco();
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, IDX_VCO_TUNE, {6'h3F, i[1:0]});
      chk("trim", {26'h0, trim}, 32'h3F);
      chk("neg_res", {30'h0, hi, lo}, {30'h0, i[1:0]});
      bus(1'b0, IDX_VCO_TUNE_RB, 8'h00);
      chk("vco_rb", q, {24'h0, 6'h3F, i[1:0]});
    end
    bus(1'b1, IDX_GEN_RESET, 8'h01);
    bus(1'b0, IDX_VCO_TUNE_RB, 8'h00);
    chk("vco_rb_rst", q, 32'h0);
    chk("trim_rst", {26'h0, trim}, 32'h0);
    be <= 4'h0;
    bus(1'b1, IDX_VCO_TUNE, 8'hFF);
    be <= 4'hF;
    chk("lane_off_wr", {26'h0, trim}, 32'h0);
  endtask : t_vco

  task t_irq();
    bus(1'b0, IDX_IRQ_STATUS, 8'h00);
    chk("irq_status", q, 32'h0F);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    bus(1'b1, IDX_IRQ_ENABLE, 8'h01);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    bus(1'b1, IDX_IRQ_CLEAR, 8'h0F);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    bus(1'b0, 8'h10, 8'h00);
    chk("unmapped_rd", q, 32'h0);
    bus(1'b0, IDX_FB_LOW, 8'h00);
    chk("wo_rd", q, 32'h0);
  endtask : t_irq

  // Mid-run reset: every committed value must fall back to its reset state.
  task t_rst();
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("rst_fb", {14'h0, fb}, {14'h0, RST_FB_DIV});
    chk("rst_ref", {16'h0, rf}, {16'h0, RST_REF_DIV});
    chk("rst_run", {31'h0, run}, 32'h0);
    chk("rst_vco_en", {31'h0, vco}, 32'h0);
    chk("rst_wait", {31'h0, waitreq}, 32'h1);
    nrst <= 1'b1;
    @(posedge sys_clk);
    bus(1'b0, IDX_FB_TOP_RB, 8'h00);
    chk("rst_fb_top_rb", q, {24'h0, RST_BYTE});
    bus(1'b0, IDX_REF_LOW_RB, 8'h00);
    chk("rst_ref_low_rb", q, {24'h0, RST_BYTE});
  endtask : t_rst

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    t_fb();
    t_ref();
    t_vco();
    t_irq();
    t_rst();
    end_of_test();
  end
endmodule : tb_pll_divider_vco_regs

`default_nettype wire
